// ---- rtl/pss_pkg.sv ----
// Behaviour
// - loading a set overwrites the live feature values with the stored ones
// - a loaded set is applied whole in one cycle, before any following frame
// - number of sets equals the set selector range; selector reaches every set
// - feature membership enables are one shared table for all sets
// - store command copies live member values into the selected set
// - restore command brings the selected set back so host can read it
// - each set holds several paths, each with own trigger and target set
// - a path trigger while running makes that path's target set active
// - path origin and qualifier work like the acquisition trigger settings
// - every set stores its paths: target, origin and qualifier each
// - switching run on first loads the initial set
// - initial set index takes the same range as the set selector
// - current set index is updated each time a set is loaded
// - with several armed paths the first trigger to occur wins
// - run switch on enables automatic switching, off disables it
// - edit mode switch on enables set configuration, off disables it
// - while running, triggers and transitions need no host action
// - feature selector enumerates every feature that may be a member
// - a path may target its own set and stays there on each trigger
// - timer expiry events are usable as path triggers
// - captured frames can be tagged with the set used to take them
// - restore changes live state even while run switch is off
// - origin off disables the path so it never causes a transition
package pss_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_SETS = 4;
  localparam int SET_W = 2;
  localparam int NUM_PATHS = 2;
  localparam int PATH_W = 1;
  localparam int NUM_FEAT = 3;
  localparam int FEAT_W = 2;
  localparam int VAL_W = 16;
  localparam int NUM_SRC = 8;
  localparam int SRC_W = 3;
  localparam int QUAL_W = 3;

  // ****************************************
  // trigger origins and qualifiers
  // ****************************************
  localparam logic [SRC_W-1:0] SRC_OFF = 3'h0;
  localparam logic [SRC_W-1:0] SRC_EXPOSURE_DONE = 3'h1;
  localparam logic [SRC_W-1:0] SRC_FRAME_START = 3'h2;
  localparam logic [SRC_W-1:0] SRC_INPUT_PIN_ZERO = 3'h3;
  localparam logic [SRC_W-1:0] SRC_TIMER_A_EXPIRY = 3'h4;
  localparam logic [SRC_W-1:0] SRC_TIMER_B_EXPIRY = 3'h5;
  localparam logic [QUAL_W-1:0] QUAL_RISING = 3'h0;
  localparam logic [QUAL_W-1:0] QUAL_FALLING = 3'h1;
  localparam logic [QUAL_W-1:0] QUAL_ANY_EDGE = 3'h2;
  localparam logic [QUAL_W-1:0] QUAL_LEVEL_HIGH = 3'h3;
  localparam logic [QUAL_W-1:0] QUAL_LEVEL_LOW = 3'h4;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SELECT = 8'h04;
  localparam logic [7:0] REG_INITIAL = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_FEAT_SEL = 8'h14;
  localparam logic [7:0] REG_FEAT_INC = 8'h18;
  localparam logic [7:0] REG_FEAT_VAL = 8'h1c;
  localparam logic [7:0] REG_PATH_CFG = 8'h20;
  localparam logic [7:0] REG_INFO = 8'h24;
  localparam logic [7:0] REG_FEAT_ID = 8'h28;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_EDIT_BIT = 1;
  localparam int CMD_STORE_BIT = 0;
  localparam int CMD_RESTORE_BIT = 1;
  localparam int SEL_PATH_LSB = 8;
  localparam int PATH_ORIGIN_LSB = 8;
  localparam int PATH_QUAL_LSB = 16;
  localparam int STATUS_RUN_BIT = 8;
  localparam int STATUS_FRAME_LSB = 16;
  localparam int INFO_PATHS_LSB = 8;
  localparam int INFO_FEAT_LSB = 16;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [VAL_W-1:0] FEAT_RESET_VAL = 16'h0000;
  localparam logic [NUM_FEAT-1:0] INCLUDE_RESET = 3'h7;
  // feature name codes (exposure, gain, width); values are arbitrary
  localparam logic [NUM_FEAT-1:0][7:0] FEAT_ID_CODES = {8'h03, 8'h02, 8'h01};

  typedef enum logic {PSS_STOPPED, PSS_RUNNING} pss_state_e;

  typedef struct packed {
    logic [SET_W-1:0] target;
    logic [SRC_W-1:0] origin;
    logic [QUAL_W-1:0] qual;
  } pss_path_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pss_wb_req_s;

  localparam pss_path_s PATH_RESET = '{target: 2'h0, origin: SRC_OFF, qual: QUAL_RISING};
endpackage

// ---- rtl/pss_trig_qual.sv ----
`timescale 1ns/100ps
module pss_trig_qual
  import pss_pkg::*;
(
  // event inputs, this cycle and last
  input wire logic [NUM_SRC-1:0] src_now,
  input wire logic [NUM_SRC-1:0] src_prev,
  // path trigger setting
  input wire logic [SRC_W-1:0] origin,
  input wire logic [QUAL_W-1:0] qual,
  // qualified trigger
  output logic hit
);
  // ****************************************
  // source pick and qualification
  // ****************************************
  logic cur;
  logic old;

  // same select and qualify as the acquisition trigger
  always_comb begin
    cur = src_now[origin];
    old = src_prev[origin];
    hit = 1'b0;
    if (origin != SRC_OFF) begin
      unique case (qual)
        QUAL_RISING: hit = cur & ~old;
        QUAL_FALLING: hit = ~cur & old;
        QUAL_ANY_EDGE: hit = cur ^ old;
        QUAL_LEVEL_HIGH: hit = cur;
        QUAL_LEVEL_LOW: hit = ~cur;
        default: hit = 1'b0;
      endcase
    end
  end
endmodule

// ---- rtl/pss_sequencer.sv ----
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/100ps
module pss_sequencer
  import pss_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // wishbone slave
  input wire pss_wb_req_s wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // trigger events, bit 0 unused
  input wire logic [NUM_SRC-1:0] trigger_events,
  // live camera settings
  output logic [NUM_FEAT-1:0][VAL_W-1:0] live_settings,
  output logic set_loaded,
  // set reporting
  output logic [SET_W-1:0] current_set_index,
  output logic [SET_W-1:0] frame_set_index,
  output logic running
);
  // ****************************************
  // storage and control state
  // ****************************************
  // set storage in flops, indexed by set; cheap only while sets stay few and small
  logic [NUM_SETS-1:0][NUM_FEAT-1:0][VAL_W-1:0] set_mem_r;
  pss_path_s [NUM_SETS-1:0][NUM_PATHS-1:0] path_mem_r;
  // live values and the shared membership table
  logic [NUM_FEAT-1:0][VAL_W-1:0] live_r;
  logic [NUM_FEAT-1:0] include_r;
  // host switches and selectors
  logic run_switch_r;
  logic set_edit_mode_r;
  logic [SET_W-1:0] set_index_select_r;
  logic [PATH_W-1:0] transition_path_select_r;
  logic [SET_W-1:0] initial_set_index_r;
  logic [FEAT_W-1:0] member_feature_select_r;
  // sequencing state
  logic [SET_W-1:0] current_set_r;
  logic [SET_W-1:0] frame_set_r;
  logic [NUM_SRC-1:0] src_prev_r;
  logic set_loaded_r;
  pss_state_e state_r;
  pss_state_e state_nxt;

  // ****************************************
  // bus decode
  // ****************************************
  // ack and read data registered, so the bus path stays short
  logic [31:0] rd_dat_r;
  logic ack_r;
  logic access;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] rd_cur;
  logic [31:0] wval;
  logic feat_ok;

  // one wait state: ack comes the cycle after the request is seen
  assign access = wb_req.cyc & wb_req.stb & ~ack_r;
  assign wr = access & wb_req.we;
  assign feat_ok = 32'(member_feature_select_r) < 32'(NUM_FEAT);

  // byte lanes enabled by sel
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wb_req.sel[b]}};
    end
  end

  // current contents of the addressed register
  always_comb begin
    rd_cur = 32'h0000_0000;
    unique case (wb_req.adr)
      REG_CTRL: begin
        rd_cur[CTRL_RUN_BIT] = run_switch_r;
        rd_cur[CTRL_EDIT_BIT] = set_edit_mode_r;
      end
      REG_SELECT: begin
        rd_cur[SET_W-1:0] = set_index_select_r;
        rd_cur[SEL_PATH_LSB +: PATH_W] = transition_path_select_r;
      end
      REG_INITIAL: rd_cur[SET_W-1:0] = initial_set_index_r;
      REG_STATUS: begin
        rd_cur[SET_W-1:0] = current_set_r;
        rd_cur[STATUS_RUN_BIT] = state_r == PSS_RUNNING;
        rd_cur[STATUS_FRAME_LSB +: SET_W] = frame_set_r;
      end
      REG_FEAT_SEL: rd_cur[FEAT_W-1:0] = member_feature_select_r;
      REG_FEAT_INC: rd_cur[0] = feat_ok & include_r[member_feature_select_r];
      REG_FEAT_VAL: rd_cur[VAL_W-1:0] = feat_ok ? live_r[member_feature_select_r] : 16'h0000;
      REG_PATH_CFG: begin
        rd_cur[SET_W-1:0] = path_mem_r[set_index_select_r][transition_path_select_r].target;
        rd_cur[PATH_ORIGIN_LSB +: SRC_W] = path_mem_r[set_index_select_r][transition_path_select_r].origin;
        rd_cur[PATH_QUAL_LSB +: QUAL_W] = path_mem_r[set_index_select_r][transition_path_select_r].qual;
      end
      REG_INFO: begin
        rd_cur[7:0] = 8'(NUM_SETS);
        rd_cur[INFO_PATHS_LSB +: 8] = 8'(NUM_PATHS);
        rd_cur[INFO_FEAT_LSB +: 8] = 8'(NUM_FEAT);
      end
      REG_FEAT_ID: rd_cur[7:0] = feat_ok ? FEAT_ID_CODES[member_feature_select_r] : 8'h00;
      default: rd_cur = 32'h0000_0000;
    endcase
  end

  // merged write value, unselected lanes keep old contents
  assign wval = (rd_cur & ~wmask) | (wb_req.dat & wmask);

  // ack pulse and registered read data
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_r <= 1'b0;
      rd_dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= access;
      if (access) begin
        rd_dat_r <= wb_req.we ? 32'h0000_0000 : rd_cur;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_dat_r;

  // ****************************************
  // write strobes
  // ****************************************
  // strobes, each true only in the taking cycle
  logic wr_ctrl;
  logic run_on_pulse;
  logic store_cmd;
  logic restore_cmd;
  logic edit_wr;

  assign wr_ctrl = wr && wb_req.adr == REG_CTRL;
  assign run_on_pulse = wr_ctrl & wval[CTRL_RUN_BIT] & ~run_switch_r;
  // configuration writes only count while edit mode is on
  assign edit_wr = wr & set_edit_mode_r;
  assign store_cmd = edit_wr && wb_req.adr == REG_CMD && wval[CMD_STORE_BIT];
  // restore works in any mode, so a stopped device can still be set by hand
  assign restore_cmd = wr && wb_req.adr == REG_CMD && wval[CMD_RESTORE_BIT];

  // run and edit switches, both off after reset
  always_ff @(posedge clk) begin
    if (reset) begin
      run_switch_r <= 1'b0;
      set_edit_mode_r <= 1'b0;
    end else if (wr_ctrl) begin
      run_switch_r <= wval[CTRL_RUN_BIT];
      set_edit_mode_r <= wval[CTRL_EDIT_BIT];
    end
  end

  // selectors; set and initial set selectors span exactly the set range, path and feature selectors have their own widths
  always_ff @(posedge clk) begin
    if (reset) begin
      set_index_select_r <= '0;
      transition_path_select_r <= '0;
      initial_set_index_r <= '0;
      member_feature_select_r <= '0;
    end else if (wr) begin
      if (wb_req.adr == REG_SELECT) begin
        set_index_select_r <= wval[SET_W-1:0];
        transition_path_select_r <= wval[SEL_PATH_LSB +: PATH_W];
      end
      if (wb_req.adr == REG_INITIAL) begin
        initial_set_index_r <= wval[SET_W-1:0];
      end
      if (wb_req.adr == REG_FEAT_SEL) begin
        member_feature_select_r <= wval[FEAT_W-1:0];
      end
    end
  end

  // shared membership table, one bit per feature for all sets
  always_ff @(posedge clk) begin
    if (reset) begin
      include_r <= INCLUDE_RESET;
    end else if (edit_wr && wb_req.adr == REG_FEAT_INC && feat_ok) begin
      include_r[member_feature_select_r] <= wval[0];
    end
  end

  // ****************************************
  // path triggers
  // ****************************************
  // hit flags of the active set's paths
  logic [NUM_PATHS-1:0] path_hit;
  logic any_hit;
  logic [SET_W-1:0] hit_target;

  // previous event levels for edge qualifiers
  always_ff @(posedge clk) begin
    if (reset) begin
      src_prev_r <= '0;
    end else begin
      src_prev_r <= trigger_events;
    end
  end

  // one qualifier per path of the active set
  for (genvar p = 0; p < NUM_PATHS; p++) begin : g_path
    pss_trig_qual u_qual (
      .src_now(trigger_events),
      .src_prev(src_prev_r),
      .origin(path_mem_r[current_set_r][p].origin),
      .qual(path_mem_r[current_set_r][p].qual),
      .hit(path_hit[p])
    );
  end

  // first path to fire wins; equal timing goes to the lowest path
  always_comb begin
    any_hit = 1'b0;
    hit_target = current_set_r;
    for (int p = NUM_PATHS - 1; p >= 0; p--) begin
      if (path_hit[p]) begin
        any_hit = 1'b1;
        hit_target = path_mem_r[current_set_r][p].target;
      end
    end
  end

  // ****************************************
  // sequencing
  // ****************************************
  // at most one load per cycle, picked by fixed priority
  logic load_en;
  logic [SET_W-1:0] load_idx;

  // run state follows the run switch
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PSS_STOPPED: if (run_on_pulse) state_nxt = PSS_RUNNING;
      PSS_RUNNING: if (wr_ctrl && !wval[CTRL_RUN_BIT]) state_nxt = PSS_STOPPED;
    endcase
  end

  // run state register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= PSS_STOPPED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // limitation: a trigger in a run start or restore cycle is lost
  // load source: run start, then host restore, then a path trigger
  always_comb begin
    load_en = 1'b1;
    load_idx = set_index_select_r;
    if (run_on_pulse) begin
      load_idx = initial_set_index_r;
    end else if (restore_cmd) begin
      load_idx = set_index_select_r;
    end else if (state_r == PSS_RUNNING && any_hit) begin
      load_idx = hit_target;
    end else begin
      load_en = 1'b0;
    end
  end

  // live values: whole set lands in one cycle, members only
  always_ff @(posedge clk) begin
    if (reset) begin
      live_r <= '{default: FEAT_RESET_VAL};
    end else begin
      // a load wins over a host write to the same feature
      for (int f = 0; f < NUM_FEAT; f++) begin
        if (load_en && include_r[f]) begin
          live_r[f] <= set_mem_r[load_idx][f];
        end else if (wr && wb_req.adr == REG_FEAT_VAL && 32'(member_feature_select_r) == f) begin
          live_r[f] <= wval[VAL_W-1:0];
        end
      end
    end
  end

  // active set index follows every load
  always_ff @(posedge clk) begin
    if (reset) begin
      current_set_r <= '0;
      set_loaded_r <= 1'b0;
    end else begin
      set_loaded_r <= load_en;
      if (load_en) begin
        current_set_r <= load_idx;
      end
    end
  end

  // set stamped on each finished exposure, for frame tagging
  always_ff @(posedge clk) begin
    if (reset) begin
      frame_set_r <= '0;
    end else if (trigger_events[SRC_EXPOSURE_DONE] & ~src_prev_r[SRC_EXPOSURE_DONE]) begin
      frame_set_r <= current_set_r;
    end
  end

  // ****************************************
  // set storage
  // ****************************************
  // store copies live members; non-members keep their stored value
  always_ff @(posedge clk) begin
    if (reset) begin
      set_mem_r <= '{default: '{default: FEAT_RESET_VAL}};
    end else if (store_cmd) begin
      for (int f = 0; f < NUM_FEAT; f++) begin
        if (include_r[f]) begin
          set_mem_r[set_index_select_r][f] <= live_r[f];
        end
      end
    end
  end

  // per-set path table, edited through the set and path selectors
  always_ff @(posedge clk) begin
    if (reset) begin
      path_mem_r <= '{default: '{default: PATH_RESET}};
    end else if (edit_wr && wb_req.adr == REG_PATH_CFG) begin
      path_mem_r[set_index_select_r][transition_path_select_r] <= '{
        target: wval[SET_W-1:0],
        origin: wval[PATH_ORIGIN_LSB +: SRC_W],
        qual: wval[PATH_QUAL_LSB +: QUAL_W]
      };
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // outputs straight from flops; running decodes the state register
  assign live_settings = live_r;
  assign set_loaded = set_loaded_r;
  assign current_set_index = current_set_r;
  assign frame_set_index = frame_set_r;
  assign running = state_r == PSS_RUNNING;
endmodule

// ---- tb/pss_sequencer_sva.sv ----
`timescale 1ns/100ps
module pss_sequencer_sva
  import pss_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // wishbone slave
  input wire pss_wb_req_s wb_req,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // events and settings
  input wire logic [NUM_SRC-1:0] trigger_events,
  input wire logic [NUM_FEAT-1:0][VAL_W-1:0] live_settings,
  input wire logic set_loaded,
  // set reporting
  input wire logic [SET_W-1:0] current_set_index,
  input wire logic [SET_W-1:0] frame_set_index,
  input wire logic running
);
  // ****************************************
  // request decode
  // ****************************************
  // a request is taken only while no ack is pending
  logic take_w;
  logic wr_w;
  logic ctrl_w;
  assign take_w = wb_req.cyc && wb_req.stb && !wb_ack_o;
  assign wr_w = take_w && wb_req.we;
  assign ctrl_w = wr_w && wb_req.adr == REG_CTRL && wb_req.sel[0];

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // ****************************************
  // properties
  // ****************************************
  ack_after_take_a: assert property (take_w |=> wb_ack_o)
    else $error("no ack one cycle after a taken request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  info_const_a: assert property (take_w && !wb_req.we && wb_req.adr == REG_INFO |=> wb_dat_o == 32'h00030204)
    else $error("info register read wrong");
  run_start_a: assert property (ctrl_w && wb_req.dat[CTRL_RUN_BIT] && !running |=> running && set_loaded)
    else $error("run start did not load a set");
  run_stop_a: assert property (ctrl_w && !wb_req.dat[CTRL_RUN_BIT] |=> !running)
    else $error("run switch off did not stop");
  stopped_hold_a: assert property (!running && !wr_w |=> $stable(current_set_index) && !running)
    else $error("set moved while stopped");
  // guard against values seen across a reset
  load_pulse_a: assert property ($changed(current_set_index) && !$past(reset) |-> set_loaded)
    else $error("set change without loaded pulse");
  frame_tag_a: assert property ($changed(frame_set_index) && !$past(reset) && !$past(reset, 2)
    |-> $past(trigger_events[1]) && !$past(trigger_events[1], 2))
    else $error("frame set moved without exposure edge");
  reset_off_a: assert property ($fell(reset) |-> !running && current_set_index == 2'h0)
    else $error("state after reset not off");
endmodule

bind pss_sequencer pss_sequencer_sva u_sva (.clk(clk), .reset(reset), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .trigger_events(trigger_events), .live_settings(live_settings), .set_loaded(set_loaded),
  .current_set_index(current_set_index), .frame_set_index(frame_set_index), .running(running));

// ---- tb/pss_sequencer_test.sv ----
`timescale 1ns/100ps
module pss_sequencer_test
  import pss_pkg::*;
;
  // ****************************************
  // clock, reset and design
  // ****************************************
  logic clk = 1'b0;
  logic reset = 1'b1;
  pss_wb_req_s wb_req = '0;
  logic [NUM_SRC-1:0] trigger_events = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic set_loaded;
  logic running;
  logic [NUM_FEAT-1:0][VAL_W-1:0] live_settings;
  logic [SET_W-1:0] current_set_index;
  logic [SET_W-1:0] frame_set_index;
  logic [31:0] rd;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;

  // 50 MHz
  always #10 clk = ~clk;

  pss_sequencer u_dut (.clk(clk), .reset(reset), .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .trigger_events(trigger_events), .live_settings(live_settings), .set_loaded(set_loaded),
    .current_set_index(current_set_index), .frame_set_index(frame_set_index), .running(running));

  // ****************************************
  // helpers
  // ****************************************
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // classic cycle; request held until ack is sampled, then a idle cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    @(posedge clk);
    // only the bench timeout ends a wait for ack
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk);
    end
    rd = wb_dat_o;
    wb_req <= '0;
    @(posedge clk);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  // stored value of feature f in set s
  function automatic logic [VAL_W-1:0] fv(input int s, input int f);
    return 16'h1000 + 16'(s * 16 + f);
  endfunction

  function automatic logic [31:0] pw(input logic [1:0] t, input logic [2:0] o, input logic [2:0] q);
    return {13'h0, q, 5'h0, o, 6'h0, t};
  endfunction

  task automatic cfgp(input int s, input int p, input logic [31:0] w);
    wb(1'b1, REG_SELECT, 32'(s) | (32'(p) << SEL_PATH_LSB));
    wb(1'b1, REG_PATH_CFG, w);
  endtask

  task automatic live_chk(input int s);
    for (int f = 0; f < NUM_FEAT; f++) begin
      chk("live value", {16'h0, live_settings[f]}, {16'h0, fv(s, f)});
    end
  endtask

  // edge qualifiers need the event low again before the next pulse
  task automatic pulse(input logic [NUM_SRC-1:0] ev, input logic [SET_W-1:0] exp);
    trigger_events <= ev;
    @(posedge clk);
    trigger_events <= '0;
    repeat (3) @(posedge clk);
    chk("current set", 32'(current_set_index), 32'(exp));
  endtask

  // ****************************************
  // tests
  // ****************************************
  // ceiling well above the roughly 280 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rchk("ctrl", REG_CTRL, 32'h0);
    rchk("info", REG_INFO, 32'h00030204);
    rchk("unmapped", 8'h30, 32'h0);
    rchk("feature id", REG_FEAT_ID, 32'h1);
    cfgp(0, 0, pw(2'h1, SRC_INPUT_PIN_ZERO, QUAL_RISING));
    rchk("path locked", REG_PATH_CFG, pw(2'h0, SRC_OFF, QUAL_RISING));
    $display("test reset done");
    wb(1'b1, REG_CTRL, 32'h2);
    for (int s = 0; s < NUM_SETS; s++) begin
      wb(1'b1, REG_SELECT, 32'(s));
      for (int f = 0; f < NUM_FEAT; f++) begin
        wb(1'b1, REG_FEAT_SEL, 32'(f));
        wb(1'b1, REG_FEAT_VAL, {16'h0, fv(s, f)});
      end
      wb(1'b1, REG_CMD, 32'h1);
    end
    cfgp(0, 0, pw(2'h0, SRC_EXPOSURE_DONE, QUAL_RISING));
    cfgp(0, 1, pw(2'h1, SRC_INPUT_PIN_ZERO, QUAL_RISING));
    cfgp(1, 0, pw(2'h0, SRC_EXPOSURE_DONE, QUAL_RISING));
    cfgp(1, 1, pw(2'h2, SRC_TIMER_A_EXPIRY, QUAL_LEVEL_HIGH));
    cfgp(2, 0, pw(2'h3, SRC_TIMER_B_EXPIRY, QUAL_FALLING));
    cfgp(2, 1, pw(2'h0, SRC_OFF, QUAL_LEVEL_LOW));
    cfgp(3, 0, pw(2'h0, SRC_INPUT_PIN_ZERO, QUAL_ANY_EDGE));
    rchk("path stored", REG_PATH_CFG, pw(2'h0, SRC_INPUT_PIN_ZERO, QUAL_ANY_EDGE));
    $display("test configure done");
    // restore while stopped, then with one feature left out
    wb(1'b1, REG_SELECT, 32'h2);
    wb(1'b1, REG_CMD, 32'h2);
    chk("restored set", 32'(current_set_index), 32'h2);
    live_chk(2);
    wb(1'b1, REG_FEAT_SEL, 32'h1);
    rchk("restored value", REG_FEAT_VAL, {16'h0, fv(2, 1)});
    wb(1'b1, REG_FEAT_SEL, 32'h2);
    wb(1'b1, REG_FEAT_INC, 32'h0);
    wb(1'b1, REG_FEAT_VAL, 32'hbeef);
    wb(1'b1, REG_SELECT, 32'h1);
    wb(1'b1, REG_CMD, 32'h2);
    chk("excluded value", {16'h0, live_settings[2]}, 32'hbeef);
    chk("included value", {16'h0, live_settings[0]}, {16'h0, fv(1, 0)});
    wb(1'b1, REG_FEAT_INC, 32'h1);
    $display("test restore done");
    // run from the top set index, then walk the paths
    wb(1'b1, REG_INITIAL, 32'h3);
    rchk("initial set", REG_INITIAL, 32'h3);
    wb(1'b1, REG_CTRL, 32'h3);
    chk("run start set", 32'(current_set_index), 32'h3);
    live_chk(3);
    chk("running", {31'h0, running}, 32'h1);
    pulse(8'h08, 2'h0);
    pulse(8'h02, 2'h0);
    pulse(8'h0a, 2'h0);
    pulse(8'h08, 2'h1);
    live_chk(1);
    pulse(8'h02, 2'h0);
    chk("frame set", 32'(frame_set_index), 32'h1);
    pulse(8'h08, 2'h1);
    pulse(8'h10, 2'h2);
    pulse(8'h09, 2'h2);
    pulse(8'h20, 2'h3);
    $display("test run done");
    wb(1'b1, REG_CTRL, 32'h0);
    pulse(8'h08, 2'h3);
    rchk("status", REG_STATUS, 32'h00010003);
    $display("test stop done");
    // level-low path held off by a high event, then fired by its release
    wb(1'b1, REG_CTRL, 32'h2);
    cfgp(3, 1, pw(2'h1, SRC_FRAME_START, QUAL_LEVEL_LOW));
    trigger_events <= 8'h04;
    wb(1'b1, REG_CTRL, 32'h3);
    chk("level held", 32'(current_set_index), 32'h3);
    pulse(8'h00, 2'h1);
    $display("test level done");
    results();
  end
endmodule
